/* File: bench/qdac_dev_model.sv */
// behavioural quad converter answering the host controller pins
`timescale 1ns/1ps
module qdac_dev_model (
    input wire qdac_pkg::pins_t pins_i,
    input wire logic [11:0] host_d_i,
    input wire logic host_oe_i,
    output logic [11:0] bus_o
);
    import qdac_pkg::*;
    logic [11:0] c1 [4];
    logic [11:0] c2 [4];
    logic [7:0] rng1;
    logic [7:0] rng2; // gains low nibble, polarity high nibble
    logic [11:0] last = 12'h000;
    logic sel, rd, ls, rs;
    always @(pins_i or host_d_i or host_oe_i) begin
        sel = !pins_i.chip_select_n;
        rd = sel && !pins_i.readback_strobe_n;
        ls = !pins_i.latch_strobe_n;
        rs = !pins_i.range_strobe_n;
        // released bus shows the inverse so stale data never looks valid
        bus_o = host_oe_i ? host_d_i : ~last;
        if (!pins_i.reset_n) begin
            rng1 = 8'h00;
            rng2 = 8'h00;
            for (int i = 0; i < 4; i++) begin
                c1[i] = 12'h000;
                c2[i] = 12'h000;
            end
        end else if (rd) begin
            bus_o = rs ? {rng2, 4'h0} : c2[pins_i.channel_select];
        end else if (sel && rs) begin
            if (ls) begin
                rng1 = bus_o[11:4];
            end else begin
                rng2 = rng1;
            end
        end else if (sel && !pins_i.transparent_n && pins_i.quad_select_n == 3'h0) begin
            // level sensitive, so a tied-low transparent pin works too
            for (int i = 0; i < 4; i++) begin
                if (!ls || i == int'(pins_i.channel_select)) begin
                    c1[i] = bus_o;
                    c2[i] = bus_o;
                end
            end
        end else if (sel && ls && pins_i.quad_select_n != 3'h7) begin
            c1[pins_i.channel_select] = bus_o;
        end else if (sel) begin
            for (int i = 0; i < 4; i++) begin
                c2[i] = c1[i];
            end
        end
        if (host_oe_i || rd) begin
            last = bus_o;
        end
    end
endmodule

/* File: bench/qdac_host_asserts.sv */
// concurrent checks on the host controller ports
`timescale 1ns/1ps
module qdac_host_asserts (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic req_valid_i,
    input wire qdac_pkg::req_t req_i,
    input wire logic req_ready_o,
    input wire logic done_o,
    input wire logic [qdac_pkg::DATA_W-1:0] rd_data_o,
    input wire qdac_pkg::pins_t pins_o,
    input wire logic [qdac_pkg::DATA_W-1:0] data_o,
    input wire logic data_oe_o,
    input wire logic [qdac_pkg::DATA_W-1:0] data_i
);
    import qdac_pkg::*;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    cmd_t cmd_q;
    logic cs;
    logic rd;
    logic pre;
    assign cs = !pins_o.chip_select_n;
    assign rd = !pins_o.readback_strobe_n;
    assign pre = cmd_q == CMD_RANGE_PRELOAD || cmd_q == CMD_CODE_PRELOAD;
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            cmd_q <= CMD_RESET;
        end else if (req_valid_i && req_ready_o) begin
            cmd_q <= req_i.cmd;
        end
    end
    sequence cs_held;
        cs [*8];
    endsequence
    sequence idle_end;
        pins_o == PINS_IDLE && !data_oe_o ##1 !done_o;
    endsequence
    a_range_nibble: assert property (
        !pins_o.range_strobe_n && data_oe_o |-> data_o[3:0] == 4'h0) else $error("range low bits");
    a_cs_width: assert property ($fell(pins_o.chip_select_n) |-> cs_held)
        else $error("select too short");
    a_strobe_first: assert property ($fell(pins_o.chip_select_n) |->
        $stable(pins_o.latch_strobe_n) && $stable(pins_o.range_strobe_n)) else $error("strobe late");
    a_load_order: assert property (!pre && cs && $rose(pins_o.latch_strobe_n) |=> cs)
        else $error("select rose with latch");
    a_preload_order: assert property (pre && $rose(pins_o.latch_strobe_n) |-> !cs)
        else $error("preload reached second rank");
    a_write_drives: assert property (
        cs && !rd && (!pins_o.latch_strobe_n || !pins_o.transparent_n) |->
        data_oe_o && $past(data_oe_o)) else $error("write without data");
    a_read_floats: assert property (rd |-> !data_oe_o) else $error("drive during read");
    a_transp_pins: assert property (cs && !pins_o.transparent_n |->
        pins_o.quad_select_n == 3'h0 && pins_o.range_strobe_n && !rd) else $error("transparent pins");
    a_reset_width: assert property ($fell(pins_o.reset_n) |->
        (!pins_o.reset_n && !cs) [*8]) else $error("reset pulse short");
    a_done_idle: assert property (done_o |-> idle_end) else $error("done while busy");
    a_answer_bound: assert property (req_valid_i && req_ready_o |-> ##[2:80] done_o)
        else $error("no done");
endmodule
bind qdac_host qdac_host_asserts i_qdac_host_asserts (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .done_o(done_o),
    .rd_data_o(rd_data_o), .pins_o(pins_o), .data_o(data_o), .data_oe_o(data_oe_o),
    .data_i(data_i));

/* File: bench/quad_dac_mode_and_transparent_load_test.sv */
// self-checking bench of the host controller against a behavioural converter
`timescale 1ns/1ps
module quad_dac_mode_and_transparent_load_test;
    import qdac_pkg::*;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic req_valid_i = 1'b0;
    req_t req_i = '0;
    logic req_ready_o, done_o, data_oe_o;
    logic [11:0] rd_data_o, data_o, data_i;
    pins_t pins_o;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    qdac_host i_qdac_host (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i),
        .req_i(req_i), .req_ready_o(req_ready_o), .done_o(done_o), .rd_data_o(rd_data_o),
        .pins_o(pins_o), .data_o(data_o), .data_oe_o(data_oe_o), .data_i(data_i));
    qdac_dev_model i_qdac_dev_model (.pins_i(pins_o), .host_d_i(data_o),
        .host_oe_i(data_oe_o), .bus_o(data_i));
    initial begin
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    task automatic final_report();
        if (fails == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // some 30 commands of under 60 cycles each
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic op(input cmd_t c, input logic [1:0] ch, input logic [11:0] d);
        int n;
        n = 0;
        @(negedge ref_clk_i);
        while (req_ready_o !== 1'b1) @(negedge ref_clk_i);
        req_valid_i = 1'b1;
        req_i = '{c, ch, d};
        @(negedge ref_clk_i);
        req_valid_i = 1'b0;
        while (done_o !== 1'b1 && n < 300) begin
            n++;
            @(negedge ref_clk_i);
        end
        if (done_o !== 1'b1) begin
            fails++;
            $display("[ERR] done expected 1 seen 0");
        end
    endtask
    task automatic rb(input cmd_t c, input logic [1:0] ch, input logic [11:0] exp);
        op(c, ch, 12'h000);
        chk(c.name(), rd_data_o, exp);
    endtask
    initial begin
        repeat (16) @(negedge ref_clk_i);
        nrst_i = 1'b1;
        op(CMD_RESET, 2'h0, 12'h000);
        rb(CMD_READ_RANGE, 2'h0, 12'h000);
        op(CMD_RANGE_LOAD, 2'h0, 12'h03c);
        rb(CMD_READ_RANGE, 2'h0, 12'h3c0);
        chk("gain", {8'h00, i_qdac_dev_model.rng2[3:0]}, 12'h00c);
        chk("polarity", {8'h00, i_qdac_dev_model.rng2[7:4]}, 12'h003);
        // upper nibble of the request must not leak into the range word
        op(CMD_RANGE_PRELOAD, 2'h0, 12'hf5a);
        rb(CMD_READ_RANGE, 2'h0, 12'h3c0);
        // apply must copy the first rank, not whatever stands on the bus
        op(CMD_RANGE_APPLY, 2'h0, 12'h0ff);
        rb(CMD_READ_RANGE, 2'h0, 12'h5a0);
        for (int i = 0; i < 4; i++) begin
            op(CMD_CODE_LOAD, 2'(i), 12'(12'h8a0 + i));
        end
        for (int i = 0; i < 4; i++) begin
            rb(CMD_READ_CODE, 2'(i), 12'(12'h8a0 + i));
        end
        op(CMD_CODE_PRELOAD, 2'h1, 12'habc);
        rb(CMD_READ_CODE, 2'h1, 12'h8a1);
        op(CMD_CODE_UPDATE, 2'h0, 12'h000);
        rb(CMD_READ_CODE, 2'h1, 12'habc);
        op(CMD_FULL_TRANSP, 2'h0, 12'h777);
        for (int i = 0; i < 4; i++) begin
            rb(CMD_READ_CODE, 2'(i), 12'h777);
        end
        op(CMD_PART_TRANSP, 2'h2, 12'h123);
        rb(CMD_READ_CODE, 2'h2, 12'h123);
        rb(CMD_READ_CODE, 2'h3, 12'h777);
        op(CMD_RESET, 2'h0, 12'h000);
        rb(CMD_READ_RANGE, 2'h0, 12'h000);
        rb(CMD_READ_CODE, 2'h2, 12'h000);
        final_report();
    end
endmodule

/* File: hdl/qdac_host.sv */
// host controller sequencing strobes and data port of the quad converter
`timescale 1ns/1ps
module qdac_host (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic req_valid_i,
    input wire qdac_pkg::req_t req_i,
    output logic req_ready_o,
    output logic done_o,
    output logic [qdac_pkg::DATA_W-1:0] rd_data_o,
    output qdac_pkg::pins_t pins_o,
    output logic [qdac_pkg::DATA_W-1:0] data_o,
    output logic data_oe_o,
    input wire logic [qdac_pkg::DATA_W-1:0] data_i
);
    import qdac_pkg::*;

    typedef enum {S_IDLE, S_SETUP, S_ASSERT, S_MID, S_RELEASE, S_HOLD, S_READ, S_FLOAT} state_t;

    state_t state_q;
    req_t cur_q;
    logic [DATA_W-1:0] sync1_q;
    logic [DATA_W-1:0] sync2_q;
    logic tmr_load;
    logic [7:0] tmr_count;
    logic tmr_done;

    qdac_timer #(.W(8)) u_timer (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .load_i(tmr_load),
        .count_i(tmr_count),
        .done_o(tmr_done)
    );

    // readback pins come from the device, so sync before use
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= data_i;
            sync2_q <= sync1_q;
        end
    end

    function automatic logic is_read(input cmd_t c);
        return (c == CMD_READ_CODE) || (c == CMD_READ_RANGE);
    endfunction

    // the two-step latch/select order decides preload versus load
    function automatic logic ls_rises_first(input cmd_t c);
        return (c == CMD_CODE_LOAD) || (c == CMD_RANGE_LOAD);
    endfunction

    // strobe levels while select is held low; reset instead keeps select high with reset_n low
    function automatic pins_t active_pins(input req_t r);
        pins_t p;
        p = PINS_IDLE;
        p.chip_select_n = 1'b0;
        p.channel_select = r.chan;
        p.quad_select_n = 3'h0;
        case (r.cmd)
            CMD_CODE_LOAD, CMD_CODE_PRELOAD: begin
                p.latch_strobe_n = 1'b0;
            end
            CMD_CODE_UPDATE: begin
                p.quad_select_n = 3'h7;
            end
            CMD_RANGE_LOAD, CMD_RANGE_PRELOAD: begin
                p.range_strobe_n = 1'b0;
                p.latch_strobe_n = 1'b0;
                p.quad_select_n = 3'h1;
            end
            CMD_RANGE_APPLY: begin
                p.range_strobe_n = 1'b0;
            end
            CMD_FULL_TRANSP: begin
                p.transparent_n = 1'b0;
            end
            CMD_PART_TRANSP: begin
                p.transparent_n = 1'b0;
                p.latch_strobe_n = 1'b0;
            end
            CMD_READ_CODE: begin
                p.readback_strobe_n = 1'b0;
            end
            CMD_READ_RANGE: begin
                p.readback_strobe_n = 1'b0;
                p.range_strobe_n = 1'b0;
                p.quad_select_n = 3'h4;
            end
            CMD_RESET: begin
                p.chip_select_n = 1'b1;
                p.reset_n = 1'b0;
            end
            default: begin
                p = PINS_IDLE;
            end
        endcase
        return p;
    endfunction

    always_comb begin
        tmr_load = 1'b0;
        tmr_count = 8'h00;
        case (state_q)
            S_IDLE: begin
                tmr_load = req_valid_i;
                tmr_count = 8'(SETUP_CYC);
            end
            S_SETUP: begin
                tmr_load = tmr_done;
                tmr_count = (cur_q.cmd == CMD_RESET) ? 8'(RESET_CYC) :
                    is_read(cur_q.cmd) ? 8'(READ_CYC) : 8'(WIDTH_CYC);
            end
            S_ASSERT, S_MID, S_RELEASE: begin
                tmr_load = tmr_done;
                tmr_count = 8'(SETUP_CYC);
            end
            S_READ: begin
                tmr_load = tmr_done;
                tmr_count = 8'(FLOAT_CYC);
            end
            default: begin
                tmr_load = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            state_q <= S_IDLE;
            cur_q <= '0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (req_valid_i) begin
                        cur_q <= req_i;
                        state_q <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    if (tmr_done) begin
                        state_q <= is_read(cur_q.cmd) ? S_READ : S_ASSERT;
                    end
                end
                S_ASSERT: begin
                    if (tmr_done) begin
                        state_q <= S_MID;
                    end
                end
                S_MID: begin
                    if (tmr_done) begin
                        state_q <= S_RELEASE;
                    end
                end
                S_RELEASE: begin
                    if (tmr_done) begin
                        state_q <= S_HOLD;
                    end
                end
                S_READ: begin
                    if (tmr_done) begin
                        state_q <= S_FLOAT;
                    end
                end
                S_HOLD, S_FLOAT: begin
                    if (tmr_done) begin
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // pin driving: setup, active window, staggered release
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            pins_o <= PINS_IDLE;
            data_o <= '0;
            data_oe_o <= 1'b0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    pins_o <= PINS_IDLE;
                    if (req_valid_i && !is_read(req_i.cmd)) begin
                        // range word lives in the upper byte, low nibble zero
                        // apply ignores the bus, but keep its low nibble zero all the same
                        if (req_i.cmd inside {CMD_RANGE_LOAD, CMD_RANGE_PRELOAD,
                            CMD_RANGE_APPLY}) begin
                            data_o <= {req_i.data[RANGE_W-1:0], 4'h0};
                        end else begin
                            data_o <= req_i.data;
                        end
                        data_oe_o <= 1'b1;
                    end
                    if (req_valid_i) begin
                        pins_o <= active_pins(req_i);
                        pins_o.chip_select_n <= 1'b1;
                        pins_o.reset_n <= 1'b1;
                    end
                end
                S_SETUP: begin
                    if (tmr_done) begin
                        pins_o <= active_pins(cur_q);
                    end
                end
                S_ASSERT: begin
                    if (tmr_done) begin
                        if (ls_rises_first(cur_q.cmd)) begin
                            pins_o.latch_strobe_n <= 1'b1;
                        end else begin
                            pins_o.chip_select_n <= 1'b1;
                            pins_o.reset_n <= 1'b1;
                        end
                    end
                end
                S_MID: begin
                    if (tmr_done) begin
                        pins_o.chip_select_n <= 1'b1;
                        pins_o.latch_strobe_n <= 1'b1;
                        pins_o.reset_n <= 1'b1;
                    end
                end
                S_RELEASE: begin
                    if (tmr_done) begin
                        pins_o <= PINS_IDLE;
                    end
                end
                S_HOLD: begin
                    if (tmr_done) begin
                        data_oe_o <= 1'b0;
                    end
                end
                S_READ: begin
                    if (tmr_done) begin
                        pins_o <= PINS_IDLE;
                    end
                end
                default: begin
                    pins_o <= PINS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            rd_data_o <= '0;
            done_o <= 1'b0;
            req_ready_o <= 1'b0;
        end else begin
            done_o <= tmr_done && (state_q == S_HOLD || state_q == S_FLOAT);
            req_ready_o <= (state_q == S_IDLE) && !req_valid_i;
            if (state_q == S_READ && tmr_done) begin
                rd_data_o <= sync2_q;
            end
        end
    end
endmodule

/* File: hdl/qdac_pkg.sv */
// constants, types and command codes for the quad converter host controller
// Function
// - range word is upper byte of twelve bits
// - range load: strobes low, select low, release
// - transparent modes always use full twelve bits
// - full transparent: quads, transparent, select low
// - partial transparent: latch strobe low, channel addressed
// - code second-rank update: select pulse, others high
package qdac_pkg;
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned DATA_W = 12;
    localparam int unsigned RANGE_W = 8;
    localparam int unsigned RANGE_LSB = 4;
    localparam int unsigned GAIN_LSB = 0;
    localparam int unsigned POL_LSB = 4;
    localparam logic [7:0] RANGE_RESET = 8'h00;
    // strobe widths in ns, worst case over temperature
    localparam int unsigned T_SETUP_NS = 15;
    localparam int unsigned T_WIDTH_NS = 110;
    localparam int unsigned T_RESET_NS = 100;
    localparam int unsigned T_READ_NS = 180;
    localparam int unsigned T_FLOAT_NS = 75;
    function automatic int unsigned ns_to_cyc(input int unsigned ns);
        int unsigned c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int unsigned SETUP_CYC = ns_to_cyc(T_SETUP_NS);
    localparam int unsigned WIDTH_CYC = ns_to_cyc(T_WIDTH_NS);
    localparam int unsigned RESET_CYC = ns_to_cyc(T_RESET_NS);
    localparam int unsigned READ_CYC = ns_to_cyc(T_READ_NS) + 2;
    localparam int unsigned FLOAT_CYC = ns_to_cyc(T_FLOAT_NS);
    typedef enum logic [3:0] {
        CMD_CODE_LOAD,
        CMD_CODE_PRELOAD,
        CMD_CODE_UPDATE,
        CMD_RANGE_LOAD,
        CMD_RANGE_PRELOAD,
        CMD_RANGE_APPLY,
        CMD_FULL_TRANSP,
        CMD_PART_TRANSP,
        CMD_READ_CODE,
        CMD_READ_RANGE,
        CMD_RESET
    } cmd_t;
    typedef struct packed {
        logic chip_select_n;
        logic latch_strobe_n;
        logic range_strobe_n;
        logic transparent_n;
        logic readback_strobe_n;
        logic reset_n;
        logic [2:0] quad_select_n;
        logic [1:0] channel_select;
    } pins_t;
    localparam pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h7, 2'h0};
    typedef struct packed {
        cmd_t cmd;
        logic [1:0] chan;
        logic [DATA_W-1:0] data;
    } req_t;
endpackage

/* File: hdl/qdac_timer.sv */
// down counter giving a one-cycle done pulse after a loaded count
`timescale 1ns/1ps
module qdac_timer #(
    parameter int unsigned W = 8
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic load_i,
    input wire logic [W-1:0] count_i,
    output logic done_o
);
    logic [W-1:0] cnt_q;
    logic run_q;
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            done_o <= 1'b0;
        end else if (load_i) begin
            cnt_q <= count_i;
            run_q <= 1'b1;
            done_o <= 1'b0;
        end else if (run_q) begin
            done_o <= (cnt_q <= W'(1));
            run_q <= (cnt_q > W'(1));
            cnt_q <= cnt_q - W'(1);
        end else begin
            done_o <= 1'b0;
        end
    end
endmodule
